/* tb.sv */
// self-checking bench for via_arbiter with a core sequencer stand-in
// assumes inputs change on the falling edge of a 100 ns core_clk
`timescale 1ns/1ps
module tb;
    import via_pkg::*;
    logic core_clk, nrst, instr_start, skip_instr, trap_op, clr_trap, ret_irq;
    logic vsel, vec_valid, en_wr, pnd_wr, stat_wr, ien_wd, slow;
    logic [14:0] next_pc, vsel_pc, vsel_target_r;
    logic [7:0]  vec_hi, vec_lo, vsel_low_r;
    logic [5:0]  src_evt, en_wd, pnd_wd, irq_en_r, irq_pnd_r;
    logic glb_en_r, trap_r, irq_req_r, ack_busy_r, stack_pop_r, vsel_jump_r;
    via_pc_s  pc_ctl_r;
    via_sel_s vsel_r;
    int num_errors = 0;
    int cmp_count  = 0;
    // ****************************************************************
    // design, partner and clock
    // ****************************************************************
    via_arbiter via_arbiter_i (.core_clk(core_clk), .nrst(nrst),
        .instr_start(instr_start), .skip_instr(skip_instr), .next_pc(next_pc),
        .trap_opcode(trap_op), .clear_trap_pending_instr(clr_trap),
        .return_from_irq_instr(ret_irq), .vector_select_instr(vsel),
        .vsel_pc(vsel_pc), .vec_valid(vec_valid), .vec_hi(vec_hi), .vec_lo(vec_lo),
        .src_evt(src_evt), .en_wr(en_wr), .en_wdata(en_wd), .pnd_wr(pnd_wr),
        .pnd_wdata(pnd_wd), .stat_wr(stat_wr), .stat_ien_wdata(ien_wd),
        .irq_en_r(irq_en_r), .irq_pnd_r(irq_pnd_r), .global_irq_enable_r(glb_en_r),
        .trap_pending_flag_r(trap_r), .irq_req_r(irq_req_r),
        .ack_busy_r(ack_busy_r), .pc_ctl_r(pc_ctl_r), .stack_pop_r(stack_pop_r),
        .vsel_r(vsel_r), .vsel_low_r(vsel_low_r), .vsel_jump_r(vsel_jump_r),
        .vsel_target_r(vsel_target_r));
    via_core_model via_core_model_i (.core_clk(core_clk), .nrst(nrst),
        .lookup(vsel_r), .slow(slow), .vec_valid(vec_valid), .vec_hi(vec_hi),
        .vec_lo(vec_lo));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // one-cycle write strobes, applied on the falling edge
    task automatic wr(input logic [5:0] en, input logic [5:0] pnd, input logic g);
        en_wr = 1'b1; en_wd = en; pnd_wr = 1'b1; pnd_wd = pnd;
        stat_wr = 1'b1; ien_wd = g;
        @(negedge core_clk);
        en_wr = 1'b0; pnd_wr = 1'b0; stat_wr = 1'b0;
    endtask : wr
    // one boundary strobe; expect no acknowledge from it
    task automatic no_ack(input logic skip);
        instr_start = 1'b1; skip_instr = skip;
        @(negedge core_clk);
        instr_start = 1'b0; skip_instr = 1'b0;
        chk(ack_busy_r, 1'b0);
    endtask : no_ack
    // acknowledge walk: push at c1, load at c7, busy c1..c7
    task automatic run_ack(input logic by_trap, input logic en_after);
        int i;
        next_pc = 15'h0123;
        if (by_trap) trap_op = 1'b1;
        else instr_start = 1'b1;
        @(negedge core_clk);
        trap_op = 1'b0; instr_start = 1'b0;
        chk(pc_ctl_r.push, 1'b1);
        chk(pc_ctl_r.ret_addr, 15'h0123);
        chk(glb_en_r, en_after);
        for (i = 1; i <= 8; i++) begin
            chk(ack_busy_r, i < 8);
            chk(pc_ctl_r.pc_load, i == 7);
            if (i == 7) chk(pc_ctl_r.pc_val, 15'h00ff);
            if (i < 8) @(negedge core_clk);
        end
    endtask : run_ack
    // vector select and table fetch through the partner
    task automatic run_sel(input logic [14:0] pc, input logic [7:0] low, input logic sl);
        int i;
        vsel = 1'b1; vsel_pc = pc; slow = sl;
        @(negedge core_clk);
        vsel = 1'b0;
        chk(vsel_r.valid, 1'b1);
        chk(vsel_low_r, low);
        chk(vsel_r.tbl_addr, {pc[14:8] + 7'(pc[7:0] == 8'hff), low});
        for (i = 0; i < 10 && vsel_jump_r !== 1'b1; i++) @(negedge core_clk);
        if (i == 10) begin
            num_errors++;
            print_verdict();
        end else begin
            chk(vsel_target_r, {low[7:1], (low + 8'h01) ^ 8'h5a});
        end
    endtask : run_sel
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        chk({irq_en_r, irq_pnd_r, glb_en_r, trap_r, ack_busy_r}, 0);
        chk(vsel_low_r, 8'he0);
        src_evt = 6'h3f;
        wr(6'h2a, 6'h00, 1'b0);
        src_evt = 6'h00;
        chk(irq_pnd_r, 6'h3f);
        chk(irq_en_r, 6'h2a);
        wr(6'h00, 6'h00, 1'b0);
        chk(irq_pnd_r, 6'h00);
    endtask : t_reset
    task automatic t_ack();
        src_evt = 6'h04;
        @(negedge core_clk);
        src_evt = 6'h00;
        wr(6'h04, 6'h04, 1'b0);
        no_ack(1'b0);
        chk(irq_req_r, 1'b0);
        wr(6'h04, 6'h04, 1'b1);
        chk(glb_en_r, 1'b1);
        no_ack(1'b1);
        chk(irq_req_r, 1'b1);
        run_ack(1'b0, 1'b0);
        wr(6'h04, 6'h00, 1'b0);
        chk(irq_pnd_r, 6'h00);
        ret_irq = 1'b1;
        @(negedge core_clk);
        ret_irq = 1'b0;
        chk({glb_en_r, stack_pop_r}, 2'b11);
        @(negedge core_clk);
        chk(stack_pop_r, 1'b0);
        no_ack(1'b0);
    endtask : t_ack
    task automatic t_sel();
        logic [7:0] slot [7] = '{8'hfa, 8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'he2, 8'he0};
        int k;
        for (k = 0; k <= 6; k++) begin
            // cleared before enabling
            wr(6'h00, 6'h00, 1'b0);
            wr(6'h3f, 6'h3f << k, 1'b0);
            run_sel(k[0] ? 15'h00ff : 15'h0234, slot[k], k[0]);
        end
    endtask : t_sel
    task automatic t_trap();
        wr(6'h3f, 6'h3f, 1'b1);
        run_ack(1'b1, 1'b1);
        chk(trap_r, 1'b1);
        no_ack(1'b0);
        run_sel(15'h0410, 8'hfe, 1'b1);
        clr_trap = 1'b1;
        @(negedge core_clk);
        clr_trap = 1'b0;
        chk(trap_r, 1'b0);
        run_ack(1'b0, 1'b0);
    endtask : t_trap
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {nrst, instr_start, skip_instr, trap_op, clr_trap, ret_irq, vsel} = '0;
        {en_wr, pnd_wr, stat_wr, ien_wd, slow, src_evt, en_wd, pnd_wd} = '0;
        next_pc = 15'h0000;
        vsel_pc = 15'h0000;
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        t_reset();
        t_ack();
        t_sel();
        t_trap();
        print_verdict();
    end
endmodule : tb

/* via_arbiter.sv */
// vectored interrupt arbiter: pending/enable flags, global enable,
// trap flag, acknowledge sequencer and vector-select address generation
// assumes the core sequencer gives one-cycle strobes, synchronous to core_clk
`timescale 1ns/1ps
module via_arbiter (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    // core sequencer strobes
    input  wire logic                        instr_start,
    input  wire logic                        skip_instr,
    input  wire logic [14:0]                 next_pc,
    input  wire logic                        trap_opcode,
    input  wire logic                        clear_trap_pending_instr,
    input  wire logic                        return_from_irq_instr,
    // vector-select instruction
    input  wire logic                        vector_select_instr,
    input  wire logic [14:0]                 vsel_pc,
    input  wire logic                        vec_valid,
    input  wire logic [7:0]                  vec_hi,
    input  wire logic [7:0]                  vec_lo,
    // source events
    input  wire logic [via_pkg::NUM_SRC-1:0] src_evt,
    // software access to flags and status word
    input  wire logic                        en_wr,
    input  wire logic [via_pkg::NUM_SRC-1:0] en_wdata,
    input  wire logic                        pnd_wr,
    input  wire logic [via_pkg::NUM_SRC-1:0] pnd_wdata,
    input  wire logic                        stat_wr,
    input  wire logic                        stat_ien_wdata,
    // flag readback
    output logic [via_pkg::NUM_SRC-1:0]      irq_en_r,
    output logic [via_pkg::NUM_SRC-1:0]      irq_pnd_r,
    output logic                             global_irq_enable_r,
    output logic                             trap_pending_flag_r,
    // towards the program counter logic
    output logic                             irq_req_r,
    output logic                             ack_busy_r,
    output via_pkg::via_pc_s                 pc_ctl_r,
    output logic                             stack_pop_r,
    output via_pkg::via_sel_s                vsel_r,
    output logic [7:0]                       vsel_low_r,
    output logic                             vsel_jump_r,
    output logic [14:0]                      vsel_target_r
);
    import via_pkg::*;

    // ****************************************************************
    // qualification and arbitration
    // ****************************************************************
    logic [NUM_SRC-1:0] active;
    logic               qual;
    logic               ack_start;
    logic               ack_trap;
    logic [7:0]         win_slot;
    logic [6:0]         tbl_block;
    logic [2:0]         ack_cnt_r;
    via_state_e         state_r;

    // enable and pending both set makes a source active
    assign active    = irq_en_r & irq_pnd_r;
    assign qual      = (|active) & global_irq_enable_r
                       & ~trap_pending_flag_r;
    // only at a normally executed instruction start or on a trap opcode, never mid-sequence
    assign ack_start = (state_r == VIA_IDLE)
                       & ((instr_start & ~skip_instr & qual)
                          | trap_opcode);
    assign ack_trap  = trap_opcode;
    // table block moves up when vector select sits on a block's last byte
    assign tbl_block = vsel_pc[14:8]
                       + {6'h00, (vsel_pc[7:0] == BLOCK_LAST)};

    // lowest rank first so higher ranks override; trap tops all
    always_comb begin
        win_slot = SLOT_DFLT;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (active[i]) begin
                win_slot = SRC_SLOT[i];
            end
        end
        if (trap_pending_flag_r) begin
            win_slot = SLOT_TRAP;
        end
    end

    // ****************************************************************
    // flags
    // ****************************************************************
    logic [NUM_SRC-1:0] en_nxt;
    logic [NUM_SRC-1:0] pnd_nxt;
    logic               glb_en_nxt;
    logic               trap_nxt;

    // a source event in the same cycle as a software clear still lands
    assign en_nxt   = en_wr ? en_wdata : irq_en_r;
    assign pnd_nxt  = (pnd_wr ? pnd_wdata : irq_pnd_r) | src_evt;
    // ack clear beats a status-word write in the same cycle
    assign glb_en_nxt = (ack_start & ~ack_trap) ? 1'b0
                      : return_from_irq_instr   ? 1'b1
                      : stat_wr ? stat_ien_wdata
                      : global_irq_enable_r;
    assign trap_nxt = trap_opcode
                      | (trap_pending_flag_r & ~clear_trap_pending_instr);

    // flag registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_en_r            <= EN_RST;
            irq_pnd_r           <= PND_RST;
            global_irq_enable_r <= 1'b0;
            trap_pending_flag_r <= 1'b0;
        end else begin
            irq_en_r            <= en_nxt;
            irq_pnd_r           <= pnd_nxt;
            global_irq_enable_r <= glb_en_nxt;
            trap_pending_flag_r <= trap_nxt;
        end
    end

    // ****************************************************************
    // acknowledge sequencer
    // ****************************************************************
    // request flag is only refreshed on boundary strobes
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_req_r <= 1'b0;
        end else if (instr_start) begin
            irq_req_r <= qual;
        end
    end

    // seven busy cycles: push on the first, pc load on the last
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_r    <= VIA_IDLE;
            ack_cnt_r  <= 3'h0;
            ack_busy_r <= 1'b0;
            pc_ctl_r   <= '0;
        end else begin
            pc_ctl_r.push    <= 1'b0;
            pc_ctl_r.pc_load <= 1'b0;
            case (state_r)
                VIA_IDLE: begin
                    if (ack_start) begin
                        state_r           <= VIA_ACK;
                        ack_cnt_r         <= 3'h0;
                        ack_busy_r        <= 1'b1;
                        pc_ctl_r.push     <= 1'b1;
                        pc_ctl_r.ret_addr <= next_pc;
                    end
                end
                VIA_ACK: begin
                    ack_cnt_r <= ack_cnt_r + 3'h1;
                    if (ack_cnt_r == ACK_LOAD) begin
                        pc_ctl_r.pc_load <= 1'b1;
                        pc_ctl_r.pc_val  <= ENTRY_ADDR;
                    end
                    if (ack_cnt_r == ACK_LAST) begin
                        state_r    <= VIA_IDLE;
                        ack_busy_r <= 1'b0;
                    end
                end
                default: state_r <= VIA_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // return and vector select
    // ****************************************************************
    // pop pulse; the core owns the stack itself
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            stack_pop_r <= 1'b0;
        end else begin
            stack_pop_r <= return_from_irq_instr;
        end
    end

    // arbitration is frozen at the first cycle of the instruction
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            vsel_r        <= '0;
            vsel_low_r    <= SLOT_DFLT;
            vsel_jump_r   <= 1'b0;
            vsel_target_r <= 15'h0000;
        end else begin
            vsel_r.valid <= vector_select_instr;
            vsel_jump_r  <= vec_valid;
            if (vector_select_instr) begin
                vsel_low_r      <= win_slot;
                vsel_r.tbl_addr <= {tbl_block, win_slot};
            end
            if (vec_valid) begin
                // high byte sits at the lower address; its top bit is unused
                vsel_target_r <= {vec_hi[6:0], vec_lo};
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_ack_length: assert property (
        $rose(ack_busy_r) |-> ack_busy_r [*7] ##1 !ack_busy_r)
        else $error("acknowledge not seven cycles");
    chk_ack_entry: assert property (
        $rose(ack_busy_r) |-> ##6 (pc_ctl_r.pc_load && pc_ctl_r.pc_val == 15'h00ff))
        else $error("entry load missing or wrong");
    chk_ack_push: assert property (
        $rose(ack_busy_r) |-> pc_ctl_r.push && pc_ctl_r.ret_addr == $past(next_pc))
        else $error("return address not pushed");
    chk_gie_cleared: assert property (
        $rose(ack_busy_r) && !$past(trap_opcode) |-> !global_irq_enable_r)
        else $error("global enable not cleared on ack");
    chk_ack_cause: assert property (
        $rose(ack_busy_r) |-> $past(trap_opcode) || ($past(global_irq_enable_r)
            && !$past(trap_pending_flag_r) && ($past(active) != 6'h00)))
        else $error("ack without a qualified cause");
    chk_skip_wait: assert property (
        instr_start && skip_instr && !trap_opcode |=> !pc_ctl_r.push)
        else $error("ack started on a skipped instruction");
    chk_pend_sticky: assert property (
        src_evt != 6'h00 |=> (irq_pnd_r & $past(src_evt)) == $past(src_evt))
        else $error("source event lost");
    chk_return_from_irq_instr_gie: assert property (
        return_from_irq_instr && !ack_start |=> global_irq_enable_r && stack_pop_r)
        else $error("return did not restore global enable");
    chk_trap_hold: assert property (
        trap_pending_flag_r && !clear_trap_pending_instr |=> trap_pending_flag_r)
        else $error("trap flag dropped");
    chk_sel_trap: assert property (
        vector_select_instr && trap_pending_flag_r |=> vsel_low_r == 8'hfe)
        else $error("trap slot not chosen");
    chk_sel_default: assert property (
        vector_select_instr && !trap_pending_flag_r && active == 6'h00
            |=> vsel_low_r == 8'he0 && vsel_r.valid)
        else $error("default slot not chosen");
    chk_sel_block: assert property (
        vector_select_instr && vsel_pc[7:0] == 8'hff
            |=> vsel_r.tbl_addr[14:8] == $past(vsel_pc[14:8]) + 7'h01)
        else $error("table block not advanced");
    // request, ranking and software access guards
    chk_req_boundary: assert property (
        instr_start && global_irq_enable_r && !trap_pending_flag_r
            && active != 6'h00 |=> irq_req_r)
        else $error("boundary request not raised");
    chk_req_hold: assert property (
        !instr_start |=> irq_req_r == $past(irq_req_r))
        else $error("request changed off a boundary");
    chk_busy_ignore: assert property (
        ack_busy_r && (instr_start || trap_opcode) |=> !pc_ctl_r.push)
        else $error("acknowledge restarted while busy");
    chk_rank_ext: assert property (
        vector_select_instr && !trap_pending_flag_r && active[SRC_EXT]
            |=> vsel_low_r == 8'hfa)
        else $error("external source not ranked first");
    chk_low_even: assert property (
        vsel_r.valid |-> !vsel_low_r[0] && vsel_low_r >= 8'he0)
        else $error("vector low byte out of range");
    chk_pend_write: assert property (
        pnd_wr && src_evt == 6'h00 |=> irq_pnd_r == $past(pnd_wdata))
        else $error("pending write lost");
    chk_trap_clear: assert property (
        clear_trap_pending_instr && !trap_opcode |=> !trap_pending_flag_r)
        else $error("trap flag not cleared");

    cov_mask_ack: cover property ($rose(ack_busy_r) && global_irq_enable_r == 1'b0);
    cov_trap_ack: cover property (trap_opcode ##1 ack_busy_r);
    cov_sel_ext:  cover property (vector_select_instr ##1 vsel_low_r == 8'hfa);
    cov_nested:   cover property (ack_busy_r && stat_wr && stat_ien_wdata);

endmodule : via_arbiter

/* via_core_model.sv */
// core sequencer stand-in: answers vector-table fetches from program memory
// assumes vector-select lookups come from via_arbiter on the shared core_clk
`timescale 1ns/1ps
module via_core_model (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         nrst,
    // lookup request and pacing
    input  via_pkg::via_sel_s lookup,
    input  wire logic         slow,
    // table bytes back
    output logic              vec_valid,
    output logic [7:0]        vec_hi,
    output logic [7:0]        vec_lo
);
    import via_pkg::*;
    // ****************************************************************
    // fetch pacing
    // ****************************************************************
    logic [2:0]  cnt_r;
    logic [14:0] addr_r;
    // released bytes flip each cycle so a stale value never passes
    always_ff @(posedge core_clk) begin
        vec_valid <= 1'b0;
        vec_hi    <= ~vec_hi;
        vec_lo    <= ~vec_lo;
        if (!nrst) begin
            cnt_r  <= 3'h0;
            addr_r <= 15'h0000;
            vec_hi <= 8'h00;
            vec_lo <= 8'h00;
        end else if (lookup.valid) begin
            addr_r <= lookup.tbl_addr;
            cnt_r  <= slow ? 3'h4 : 3'h1;
        end else if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
            if (cnt_r == 3'h1) begin
                // hi from even address, spare top bit set
                vec_valid <= 1'b1;
                vec_hi    <= {1'b1, addr_r[7:1]};
                vec_lo    <= (addr_r[7:0] + 8'h01) ^ 8'h5a;
            end
        end
    end
endmodule : via_core_model

/* via_pkg.sv */
// constants, slot table and carrier types for the vectored interrupt arbiter
// assumes a single instruction-cycle clock shared with the core sequencer
package via_pkg;

    // ****************************************************************
    // source layout and timing
    // ****************************************************************
    localparam int          NUM_SRC     = 6;
    localparam int          SRC_EXT     = 0;   // external input pin
    localparam int          SRC_IDLE    = 1;   // idle timer
    localparam int          SRC_T2A     = 2;   // two-event timer, event a
    localparam int          SRC_T2B     = 3;   // two-event timer, event b
    localparam int          SRC_SER     = 4;   // synchronous serial interface
    localparam int          SRC_WAKE    = 5;   // port-l wakeup edges
    localparam logic [14:0] ENTRY_ADDR  = 15'h00ff;
    localparam int          ACK_CYCLES  = 7;   // instruction cycles
    localparam logic [2:0]  ACK_LAST    = 3'(ACK_CYCLES - 1);
    localparam logic [2:0]  ACK_LOAD    = 3'(ACK_CYCLES - 2);

    // ****************************************************************
    // vector table low bytes, index = source number
    // ****************************************************************
    localparam logic [NUM_SRC-1:0][7:0] SRC_SLOT =
        {8'he2, 8'hf2, 8'hf4, 8'hf6, 8'hf8, 8'hfa};
    localparam logic [7:0]  SLOT_TRAP   = 8'hfe;
    localparam logic [7:0]  SLOT_DFLT   = 8'he0;
    localparam logic [7:0]  BLOCK_LAST  = 8'hff;

    // ****************************************************************
    // reset values and carriers
    // ****************************************************************
    localparam logic [NUM_SRC-1:0] EN_RST  = '0;
    localparam logic [NUM_SRC-1:0] PND_RST = '0;

    typedef enum logic [0:0] {
        VIA_IDLE = 1'b0,
        VIA_ACK  = 1'b1
    } via_state_e;

    // what the core program-counter logic must do
    typedef struct packed {
        logic        push;       // push ret_addr onto the stack
        logic [14:0] ret_addr;
        logic        pc_load;    // load pc_val into the program counter
        logic [14:0] pc_val;
    } via_pc_s;

    // vector-select lookup towards program memory
    typedef struct packed {
        logic        valid;
        logic [14:0] tbl_addr;   // address of the high byte
    } via_sel_s;

endpackage : via_pkg
